//--- logic/lcdrs_mem.sv
// Dual-port dot memory with registered read data on both ports
`timescale 1ns/1ps
`default_nettype none
module lcdrs_mem #(
  parameter int AW = 11,
  parameter int DW = 8,
  parameter int DEPTH = 1188
) (
  input wire logic clk,
  input wire logic a_we,
  input wire logic [AW-1:0] a_addr,
  input wire logic [DW-1:0] a_wdata,
  output logic [DW-1:0] a_rdata,
  input wire logic [AW-1:0] b_addr,
  output logic [DW-1:0] b_rdata
);
  logic [DW-1:0] mem [DEPTH];

  // Host port: write or read
  always_ff @(posedge clk) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    a_rdata <= mem[a_addr];
  end

  // Refresh port is read-only, so it never disturbs host data
  always_ff @(posedge clk) begin
    b_rdata <= mem[b_addr];
  end
endmodule
`default_nettype wire

//--- logic/lcdrs_top.sv
// LCD dot memory with APB access, scan timing, output latch and cascade pins
// Function
// - 65x132 dot memory, page plus column addressing
// - Host byte maps to eight vertical dots
// - Host access independent of refresh readout
// - Page 8 keeps only bit 0
// - Column increments after each data access
// - Column increment saturates at 83h
// - Mirror bit reverses column-to-segment order
// - Start line picks top row, scrolls
// - Indicator row always shows line 65
// - Reverse, off, all-on act on latch only
// - Oscillator runs only when source select high
// - Dot clock makes line and latch strobes
// - Polarity alternates over two frames
// - Master drives polarity and blanking pins, dot pin only with own oscillator; slave receives
// - Row scan direction normal or reversed
// - Power bits enable pump, regulator, follower
// - Contrast setting has 64 steps
// - Reset clears column, page, start line
`timescale 1ns/1ps
`default_nettype none
module lcdrs_top
  import lcdrs_pkg::*;
#(
  parameter int COLS = NUM_COLS,
  parameter int ROWS = NUM_ROWS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic oscillator_source_select,
  input wire logic dot_timing_pin_i,
  output logic dot_timing_pin_o,
  output logic dot_timing_pin_oe,
  input wire logic ac_polarity_signal_i,
  output logic ac_polarity_signal_o,
  output logic ac_polarity_signal_oe,
  input wire logic blanking_sync_signal_n_i,
  output logic blanking_sync_signal_n_o,
  output logic blanking_sync_signal_n_oe,
  output logic [COLS-1:0] column_driver_output,
  output logic [6:0] row_select,
  output logic indicator_row_driver,
  output logic osc_run,
  output logic [2:0] power_enable,
  output logic [5:0] contrast
);
  // Configuration registers
  logic disp_on_q, reverse_q, all_on_q, seg_mirror_q, row_rev_q, master_q;
  logic [5:0] start_q;
  logic [5:0] contrast_q;
  logic [2:0] power_q;
  logic [7:0] col_q;
  logic [3:0] page_q;

  // APB decode; one wait state so a read sees memory output
  logic setup, access, wr_acc, rd_acc, ack_q;
  logic hit_data;
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit_data = (paddr == OFF_DATA);
  assign wr_acc = access && pwrite && !ack_q;
  assign rd_acc = access && !pwrite && !ack_q;

  // Memory host port
  logic [MEM_AW-1:0] host_addr;
  logic [7:0] host_wdata, host_rdata;
  logic host_we;
  assign host_addr = MEM_AW'(page_q * COLS + col_q);
  // Indicator page stores bit 0 only
  assign host_wdata = (page_q == PAGE_IND) ? {7'h00, pwdata[0]} : pwdata[7:0];
  assign host_we = wr_acc && hit_data && (col_q <= COL_LAST) && (page_q <= PAGE_IND);

  // Ready one cycle after access begins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access && !ack_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access && !pready;
    end
  end

  // Unmapped offsets answer with slave error
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access && !pready && !(paddr == OFF_CTRL || paddr == OFF_ADDR ||
                 hit_data || paddr == OFF_POWER || paddr == OFF_STATUS);
    end
  end

  // Read mux, data taken from memory after the wait state
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      OFF_CTRL: rd_mux = {10'h000, contrast_q, 2'b00, start_q, 2'b00, master_q, row_rev_q,
                          seg_mirror_q, all_on_q, reverse_q, disp_on_q};
      OFF_ADDR: rd_mux = {20'h00000, page_q, col_q};
      OFF_DATA: rd_mux = {24'h000000, host_rdata};
      OFF_POWER: rd_mux = {29'h0, power_q};
      OFF_STATUS: rd_mux = {24'h000000, seg_mirror_q, disp_on_q, osc_run, row_select[5:0] == 6'h00,
                            1'b0, power_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (access && !pready) begin
      prdata <= rd_mux;
    end
  end

  // Control register writes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      disp_on_q <= 1'b0;
      reverse_q <= 1'b0;
      all_on_q <= 1'b0;
      seg_mirror_q <= 1'b0;
      row_rev_q <= 1'b0;
      master_q <= 1'b1;
      start_q <= 6'h00;
      contrast_q <= CONTRAST_RST;
    end else if (wr_acc && paddr == OFF_CTRL) begin
      disp_on_q <= pwdata[CTRL_DISP_ON];
      reverse_q <= pwdata[CTRL_REVERSE];
      all_on_q <= pwdata[CTRL_ALL_ON];
      seg_mirror_q <= pwdata[CTRL_SEG_MIRROR];
      row_rev_q <= pwdata[CTRL_ROW_REV];
      master_q <= pwdata[CTRL_MASTER];
      start_q <= pwdata[CTRL_START_LSB +: 6];
      contrast_q <= pwdata[CTRL_CONTRAST_LSB +: 6];
    end
  end

  // Power enables: bit2 pump, bit1 regulator, bit0 follower
  always_ff @(posedge clk) begin
    if (!resetn) begin
      power_q <= POWER_RST;
    end else if (wr_acc && paddr == OFF_POWER) begin
      power_q <= pwdata[2:0];
    end
  end

  // Address pointer: page never moves by itself, column saturates
  always_ff @(posedge clk) begin
    if (!resetn) begin
      col_q <= 8'h00;
      page_q <= 4'h0;
    end else if (wr_acc && paddr == OFF_ADDR) begin
      col_q <= pwdata[ADDR_COL_LSB +: 8];
      page_q <= pwdata[ADDR_PAGE_LSB +: 4];
    end else if ((wr_acc || rd_acc) && hit_data && col_q < COL_LAST) begin
      col_q <= col_q + 8'h01;
    end
  end

  // Oscillator and dot clock source; pump needs the oscillator
  logic dot_ext_s1, dot_ext_s2;
  logic ac_s1, ac_s2, blank_s1, blank_s2;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dot_ext_s1 <= 1'b0;
      dot_ext_s2 <= 1'b0;
      ac_s1 <= 1'b0;
      ac_s2 <= 1'b0;
      blank_s1 <= 1'b0;
      blank_s2 <= 1'b0;
    end else begin
      dot_ext_s1 <= dot_timing_pin_i;
      dot_ext_s2 <= dot_ext_s1;
      ac_s1 <= ac_polarity_signal_i;
      ac_s2 <= ac_s1;
      blank_s1 <= blanking_sync_signal_n_i;
      blank_s2 <= blank_s1;
    end
  end

  // A slave shows data only while the master's blanking line is high
  logic disp_eff;
  assign disp_eff = disp_on_q && (master_q || blank_s2);

  logic osc_sel_s1, osc_sel_s2;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      osc_sel_s1 <= 1'b0;
      osc_sel_s2 <= 1'b0;
    end else begin
      osc_sel_s1 <= oscillator_source_select;
      osc_sel_s2 <= osc_sel_s1;
    end
  end

  // Internal oscillator divider stops when source select is low
  logic [1:0] osc_div_q;
  logic osc_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      osc_div_q <= 2'h0;
      osc_q <= 1'b0;
    end else if (osc_sel_s2) begin
      osc_div_q <= osc_div_q + 2'h1;
      if (osc_div_q == 2'(LINE_DOTS / 2 - 1)) begin
        osc_q <= !osc_q;
        osc_div_q <= 2'h0;
      end
    end else begin
      osc_div_q <= 2'h0;
      osc_q <= 1'b0;
    end
  end

  // Display clock rising-edge pulse from the chosen source
  logic dclk_q, dclk_prev_q, dot_tick;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dclk_q <= 1'b0;
      dclk_prev_q <= 1'b0;
    end else begin
      dclk_q <= osc_sel_s2 ? osc_q : dot_ext_s2;
      dclk_prev_q <= dclk_q;
    end
  end
  assign dot_tick = dclk_q && !dclk_prev_q;

  // Line counter and scan FSM; each line step advances one line
  lcdrs_scan_e scan_q;
  logic [6:0] line_q;
  logic frame_end;
  logic ac_q;
  logic line_busy_q;
  logic line_tick;
  // A column sweep outlasts one dot period, so a line steps only once it is done
  assign line_tick = dot_tick && (scan_q == LCDRS_IDLE) && !line_busy_q;
  assign frame_end = line_tick && (line_q == 7'(ROWS));
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scan_q <= LCDRS_IDLE;
    end else begin
      case (scan_q)
        LCDRS_IDLE: scan_q <= line_tick ? LCDRS_FETCH : LCDRS_IDLE;
        LCDRS_FETCH: scan_q <= LCDRS_LATCH;
        LCDRS_LATCH: scan_q <= LCDRS_IDLE;
        default: scan_q <= LCDRS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      line_q <= 7'h00;
    end else if (line_tick) begin
      line_q <= (line_q == 7'(ROWS)) ? 7'h00 : line_q + 7'h01; // 64 rows plus indicator
    end
  end

  // Polarity flips once per frame, so each dot gets both signs; a slave follows its pin
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ac_q <= 1'b0;
    end else if (!master_q) begin
      ac_q <= ac_s2;
    end else if (frame_end) begin
      ac_q <= !ac_q;
    end
  end

  // Memory line for this scan slot; row 64 is the indicator line
  logic [5:0] mem_line;
  logic [6:0] row_phys;
  assign mem_line = 6'(start_q + line_q[5:0]);
  assign row_phys = (line_q == 7'(ROWS)) ? 7'(ROWS) :
                    (row_rev_q ? 7'(ROWS - 1) - line_q : line_q);
  logic [3:0] scan_page;
  logic [2:0] scan_bit;
  assign scan_page = (line_q == 7'(ROWS)) ? PAGE_IND : {1'b0, mem_line[5:3]};
  assign scan_bit = (line_q == 7'(ROWS)) ? 3'h0 : mem_line[2:0];

  // Refresh sweeps columns through the read-only port
  logic [7:0] scan_col_q;
  logic [MEM_AW-1:0] scan_addr;
  logic [7:0] scan_rdata;
  logic [COLS-1:0] line_buf_q;
  assign scan_addr = MEM_AW'(scan_page * COLS + scan_col_q);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scan_col_q <= 8'h00;
      line_busy_q <= 1'b0;
    end else if (scan_q == LCDRS_FETCH) begin
      scan_col_q <= 8'h00;
      line_busy_q <= 1'b1;
    end else if (line_busy_q) begin
      scan_col_q <= scan_col_q + 8'h01;
      line_busy_q <= scan_col_q != 8'(COLS);
    end
  end

  // Collect one bit per column; read data lags address by one cycle
  logic [7:0] cap_col_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cap_col_q <= 8'h00;
    end else begin
      cap_col_q <= scan_col_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < COLS; gi = gi + 1) begin : g_col
      always_ff @(posedge clk) begin
        if (!resetn) begin
          line_buf_q[gi] <= 1'b0;
        end else if (line_busy_q && cap_col_q == 8'(gi)) begin
          line_buf_q[gi] <= scan_rdata[scan_bit];
        end
      end
      // Output latch with mirror, reverse, on/off and all-on
      always_ff @(posedge clk) begin
        if (!resetn) begin
          column_driver_output[gi] <= 1'b0;
        end else if (line_tick) begin
          column_driver_output[gi] <= disp_eff &&
            (all_on_q || (reverse_q ^ line_buf_q[seg_mirror_q ? COLS - 1 - gi : gi]));
        end
      end
    end
  endgenerate

  lcdrs_mem #(
    .AW(MEM_AW),
    .DW(8),
    .DEPTH(NUM_PAGES * COLS)
  ) u_mem (
    .clk(clk),
    .a_we(host_we),
    .a_addr(host_addr),
    .a_wdata(host_wdata),
    .a_rdata(host_rdata),
    .b_addr(scan_addr),
    .b_rdata(scan_rdata)
  );

  // Row and indicator drivers plus status outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      row_select <= 7'h00;
      indicator_row_driver <= 1'b0;
      osc_run <= 1'b0;
      power_enable <= POWER_RST;
      contrast <= CONTRAST_RST;
    end else begin
      if (line_tick) begin
        row_select <= row_phys;
        indicator_row_driver <= disp_eff && (line_q == 7'(ROWS));
      end
      osc_run <= osc_sel_s2;
      power_enable <= power_q;
      contrast <= contrast_q;
    end
  end

  // Cascade pins: master drives polarity and blanking, dot pin only with own oscillator
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ac_polarity_signal_o <= 1'b0;
      ac_polarity_signal_oe <= 1'b0;
      blanking_sync_signal_n_o <= 1'b0;
      blanking_sync_signal_n_oe <= 1'b0;
      dot_timing_pin_o <= 1'b0;
      dot_timing_pin_oe <= 1'b0;
    end else begin
      ac_polarity_signal_o <= ac_q;
      ac_polarity_signal_oe <= master_q;
      blanking_sync_signal_n_o <= disp_on_q;
      blanking_sync_signal_n_oe <= master_q;
      dot_timing_pin_o <= osc_q;
      dot_timing_pin_oe <= master_q && osc_sel_s2;
    end
  end
endmodule
`default_nettype wire

//--- shared/lcdrs_pkg.sv
// Shared constants for the LCD dot memory, scan timing and register map
package lcdrs_pkg;
  // Memory geometry
  localparam int NUM_COLS = 132;
  localparam int NUM_PAGES = 9;
  localparam int NUM_ROWS = 64;
  localparam logic [7:0] COL_LAST = 8'h83;
  localparam logic [3:0] PAGE_IND = 4'h8;
  localparam int MEM_AW = 11;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_POWER = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  // Control register fields
  localparam int CTRL_DISP_ON = 0;
  localparam int CTRL_REVERSE = 1;
  localparam int CTRL_ALL_ON = 2;
  localparam int CTRL_SEG_MIRROR = 3;
  localparam int CTRL_ROW_REV = 4;
  localparam int CTRL_MASTER = 5;
  localparam int CTRL_START_LSB = 8;
  localparam int CTRL_CONTRAST_LSB = 16;
  // Address register fields
  localparam int ADDR_COL_LSB = 0;
  localparam int ADDR_PAGE_LSB = 8;
  // Reset values
  localparam logic [5:0] CONTRAST_RST = 6'h20;
  localparam logic [2:0] POWER_RST = 3'h0;
  // Dot clock period in system clocks (a line steps on the first dot clock after its column sweep)
  localparam int LINE_DOTS = 4;
  // Scan states, Gray coded from IDLE through LATCH; the step back to IDLE flips both bits
  typedef enum logic [1:0] {
    LCDRS_IDLE = 2'b00,
    LCDRS_FETCH = 2'b01,
    LCDRS_LATCH = 2'b11
  } lcdrs_scan_e;
endpackage

//--- test/lcdrs_cascade_model.sv
// Behavioural master controller feeding the cascade pins of a slave
`timescale 1ns/1ps
`default_nettype none
module lcdrs_cascade_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic en,
  output logic dot_o,
  output logic pol_o,
  output logic blank_n_o
);
  logic [1:0] div_q = 2'h0;
  logic [6:0] line_q = 7'h00;
  logic pol_q = 1'b0;
  logic junk_q = 1'b0;
  // Dot clock of four system clocks, 65 lines a frame
  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_q <= 2'h0;
      line_q <= 7'h00;
      pol_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        line_q <= (line_q == 7'h40) ? 7'h00 : line_q + 7'h01;
        pol_q <= (line_q == 7'h40) ? !pol_q : pol_q;
      end
    end
    junk_q <= !junk_q;
  end
  // Released lines flip every cycle so no stale level can pass
  assign dot_o = en ? div_q[1] : junk_q;
  assign pol_o = en ? pol_q : junk_q;
  assign blank_n_o = en ? 1'b1 : junk_q;
endmodule
`default_nettype wire

//--- test/lcdrs_top_bench.sv
// APB-driven bench for the LCD dot memory, scan and cascade pins
`timescale 1ns/1ps
`default_nettype none
module lcdrs_top_bench;
  import lcdrs_pkg::*;
  localparam logic [31:0] WD = 32'ha53c7710;
  localparam logic [11:0] PW = 12'b111_011_001_000;
  logic clk = 1'b0;
  logic resetn, psel, penable, pwrite, osc_sel, m_en, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic dot_o, dot_oe, pol_o, pol_oe, blk_o, blk_oe, ind, osc_run;
  logic m_dot, m_pol, m_blk, dot_w, pol_w, blk_w;
  logic [NUM_COLS-1:0] seg_out;
  logic [6:0] row_select;
  logic [2:0] power_enable;
  logic [5:0] contrast;
  int failures = 0;
  int cmp_count = 0;
  // 10 MHz system clock
  always #50 clk = !clk;
  // Pin level comes from whichever side enables its driver
  assign dot_w = dot_oe ? dot_o : m_dot;
  assign pol_w = pol_oe ? pol_o : m_pol;
  assign blk_w = blk_oe ? blk_o : m_blk;
  lcdrs_top i_lcdrs_top (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oscillator_source_select(osc_sel), .dot_timing_pin_i(dot_w),
    .dot_timing_pin_o(dot_o), .dot_timing_pin_oe(dot_oe), .ac_polarity_signal_i(pol_w),
    .ac_polarity_signal_o(pol_o), .ac_polarity_signal_oe(pol_oe),
    .blanking_sync_signal_n_i(blk_w), .blanking_sync_signal_n_o(blk_o),
    .blanking_sync_signal_n_oe(blk_oe), .column_driver_output(seg_out),
    .row_select(row_select), .indicator_row_driver(ind), .osc_run(osc_run),
    .power_enable(power_enable), .contrast(contrast));
  lcdrs_cascade_model i_lcdrs_cascade_model (.clk(clk), .resetn(resetn), .en(m_en),
    .dot_o(m_dot), .pol_o(m_pol), .blank_n_o(m_blk));
  task automatic conclude();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  // One APB transfer; caller stands just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n == 40) chk("pready", 32'h1, 32'(pready));
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
  endtask
  // Wait until row_select equals r (hit) or differs from it (no hit)
  task automatic wait_row(input logic [6:0] r, input logic hit);
    int n;
    n = 0;
    while ((row_select === r) != hit && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 20000) chk("row", 32'(hit), 32'(row_select === r));
  endtask
  // Stop on a rising edge two clocks after row r is latched
  task automatic at_row(input logic [6:0] r);
    wait_row(r, 1'b1);
    repeat (2) @(posedge clk);
  endtask
  // Row r from a fetch begun after the last setting: let two line steps pass first
  task automatic frame_to(input logic [6:0] r);
    logic [6:0] s;
    s = row_select;
    wait_row(s, 1'b0);
    s = row_select;
    wait_row(s, 1'b0);
    at_row(r);
  endtask
  // Hang guard: the tests need some 70000 clocks
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    conclude();
  end
  initial begin
    logic [31:0] r;
    logic e;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    resetn = 1'b0;
    osc_sel = 1'b1; // Pump needs a running oscillator
    m_en = 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(OFF_CTRL, 32'h0020_0020, "ctrl_rst");
    rd(OFF_ADDR, 32'h0, "addr_rst");
    chk("master_oe", 32'h3, 32'({dot_oe, pol_oe}));
    chk("blank_rst", 32'h0, 32'(blk_o));
    r[0] = dot_o;
    repeat (2) @(posedge clk);
    chk("dot_o", 32'(!r[0]), 32'(dot_o));
    wr(OFF_ADDR, 32'h81);
    for (int i = 3; i >= 0; i--) wr(OFF_DATA, 32'(WD[8*i +: 8]));
    rd(OFF_ADDR, 32'h83, "col_sat");
    wr(OFF_ADDR, 32'h81);
    rd(OFF_DATA, 32'ha5, "d81");
    rd(OFF_DATA, 32'h3c, "d82");
    rd(OFF_DATA, 32'h10, "d83");
    rd(OFF_ADDR, 32'h83, "page_kept");
    wr(OFF_ADDR, 32'h805);
    wr(OFF_DATA, 32'hff);
    wr(OFF_ADDR, 32'h805);
    rd(OFF_DATA, 32'h01, "ind_bit");
    wr(OFF_ADDR, 32'h0);
    wr(OFF_DATA, 32'h01);
    // Unmapped offset is refused with zero data
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk("err", 32'h1, 32'(e));
    chk("err_data", 32'h0, r);
    for (int i = 3; i >= 0; i--) begin
      wr(OFF_POWER, 32'(PW[3*i +: 3]));
      chk("power", 32'(PW[3*i +: 3]), 32'(power_enable));
    end
    wr(OFF_CTRL, 32'h003f_0021);
    chk("contrast", 32'h3f, 32'(contrast));
    frame_to(7'h00);
    chk("seg_first", 32'h1, 32'(seg_out[0]));
    chk("seg_last", 32'h0, 32'(seg_out[131]));
    wr(OFF_CTRL, 32'h29);
    frame_to(7'h00);
    chk("seg_mir_last", 32'h1, 32'(seg_out[131]));
    chk("seg_mir_first", 32'h0, 32'(seg_out[0]));
    wr(OFF_CTRL, 32'h23);
    frame_to(7'h00);
    chk("seg_rev", 32'h0, 32'(seg_out[0]));
    wr(OFF_CTRL, 32'h25);
    frame_to(7'h00);
    chk("seg_all", 32'h1, 32'(seg_out[131]));
    wr(OFF_ADDR, 32'h0);
    rd(OFF_DATA, 32'h01, "mem_kept");
    wr(OFF_CTRL, 32'h121);
    frame_to(7'h00);
    chk("seg_start", 32'h0, 32'(seg_out[0]));
    at_row(7'h3f);
    chk("seg_wrap", 32'h1, 32'(seg_out[0]));
    at_row(7'h40);
    chk("seg_ind", 32'h1, 32'(seg_out[5]));
    chk("ind_row", 32'h1, 32'(ind));
    chk("blank_o", 32'h1, 32'(blk_o));
    wr(OFF_CTRL, 32'h31);
    frame_to(7'h3f);
    chk("seg_rscan", 32'h1, 32'(seg_out[0]));
    at_row(7'h3e);
    chk("seg_rnext", 32'h0, 32'(seg_out[0]));
    m_en <= 1'b1;
    osc_sel <= 1'b0;
    wr(OFF_CTRL, 32'h01);
    repeat (4) @(posedge clk);
    chk("slave_oe", 32'h0, 32'({dot_oe, pol_oe, blk_oe}));
    chk("osc_stop", 32'h0, 32'(osc_run));
    frame_to(7'h00);
    chk("seg_slave", 32'h1, 32'(seg_out[0]));
    conclude();
  end
endmodule
`default_nettype wire

//--- test/lcdrs_top_monitor.sv
// Checker on the scan, cascade and power ports of the LCD block
`timescale 1ns/1ps
`default_nettype none
module lcdrs_top_monitor
  import lcdrs_pkg::*;
#(
  parameter int COLS = NUM_COLS,
  parameter int ROWS = NUM_ROWS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic oscillator_source_select,
  input wire logic dot_timing_pin_oe,
  input wire logic ac_polarity_signal_o,
  input wire logic ac_polarity_signal_oe,
  input wire logic blanking_sync_signal_n_oe,
  input wire logic [6:0] row_select,
  input wire logic indicator_row_driver,
  input wire logic osc_run,
  input wire logic [2:0] power_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Power write in its access phase
  logic pwr_wr;
  assign pwr_wr = psel && penable && pwrite && paddr == OFF_POWER;
  // Select held long enough to pass the synchroniser
  sequence sel_hi;
    oscillator_source_select [*4];
  endsequence
  osc_on_a: assert property (sel_hi |-> osc_run)
    else $error("oscillator idle while selected");
  oe_pair_a: assert property (ac_polarity_signal_oe == blanking_sync_signal_n_oe)
    else $error("cascade enables differ");
  dot_oe_a: assert property (dot_timing_pin_oe |-> ac_polarity_signal_oe
    || $past(ac_polarity_signal_oe)) else $error("dot pin driven by slave");
  row_range_a: assert property (row_select <= 7'd64)
    else $error("row beyond indicator");
  ind_row_a: assert property (indicator_row_driver |-> row_select == 7'd64)
    else $error("indicator off its row");
  row_wrap_a: assert property ($past(row_select) == 7'd64 && row_select != 7'd64
    |-> row_select == 7'd0 || row_select == 7'd63) else $error("bad first row");
  pol_frame_a: assert property (ac_polarity_signal_oe && $changed(ac_polarity_signal_o)
    |-> $past(row_select) == 7'd64 || $past(row_select, 2) == 7'd64)
    else $error("polarity moved mid frame");
  power_src_a: assert property ($changed(power_enable)
    |-> $past(pwr_wr) || $past(pwr_wr, 2) || $past(pwr_wr, 3))
    else $error("power bits moved unasked");
endmodule
bind lcdrs_top lcdrs_top_monitor #(.COLS(COLS), .ROWS(ROWS)) i_lcdrs_top_monitor (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .oscillator_source_select(oscillator_source_select),
  .dot_timing_pin_oe(dot_timing_pin_oe), .ac_polarity_signal_o(ac_polarity_signal_o),
  .ac_polarity_signal_oe(ac_polarity_signal_oe),
  .blanking_sync_signal_n_oe(blanking_sync_signal_n_oe), .row_select(row_select),
  .indicator_row_driver(indicator_row_driver), .osc_run(osc_run),
  .power_enable(power_enable));
`default_nettype wire
